// File: hw/signal_modulator_pkg.sv
/*
 * Constants for the data signal modulator: register byte offsets,
 * field positions, reset values and source-select encodings.
 * Assumes a 32-bit AXI4-Lite register bus with word-aligned registers.
 */
package signal_modulator_pkg;
   // register byte offsets
   localparam logic [3:0] OFS_CONTROL = 4'h0;
   localparam logic [3:0] OFS_SOURCE = 4'h4;
   localparam logic [3:0] OFS_HIGH_CARRIER = 4'h8;
   localparam logic [3:0] OFS_LOW_CARRIER = 4'hC;

   // control register field positions
   localparam int BIT_ENABLE = 7;
   localparam int BIT_PIN_OE = 6;
   localparam int BIT_SLEW = 5;
   localparam int BIT_OUT_INV = 4;
   localparam int BIT_STATUS = 3;
   localparam int BIT_SW_MOD = 0;
   // source and carrier register field positions
   localparam int BIT_RELEASE = 7;
   localparam int BIT_CAR_INV = 6;
   localparam int BIT_CAR_SYNC = 5;

   // values after reset
   localparam logic [7:0] CONTROL_RESET = 8'h20;
   localparam logic [7:0] SOURCE_RESET = 8'h00;
   localparam logic [7:0] CARRIER_RESET = 8'h00;

   // writable bit masks
   localparam logic [7:0] CONTROL_WMASK = 8'hF1;
   localparam logic [7:0] SOURCE_WMASK = 8'h8F;
   localparam logic [7:0] CARRIER_WMASK = 8'hEF;

   // modulator source codes
   localparam logic [3:0] MOD_SW_BIT = 4'h0;
   localparam logic [3:0] MOD_PIN = 4'h1;
   localparam logic [3:0] MOD_PWM = 4'h2;
   localparam logic [3:0] MOD_COMPARATOR = 4'h6;
   localparam logic [3:0] MOD_SERIAL_DATA = 4'h8;
   localparam logic [3:0] MOD_UART_TX = 4'hA;

   // carrier source codes
   localparam logic [3:0] CAR_GROUND = 4'h0;
   localparam logic [3:0] CAR_PIN_ONE = 4'h1;
   localparam logic [3:0] CAR_PIN_TWO = 4'h2;
   localparam logic [3:0] CAR_REF_CLOCK = 4'h3;
   localparam logic [3:0] CAR_PWM = 4'h4;

   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage : signal_modulator_pkg

// File: hw/signal_modulator.sv
/*
 * Data signal modulator: selects a modulator and two carriers, gates the
 * carrier picked by the modulator level onto an output pin, with optional
 * carrier synchronisation and polarity control. Registers over AXI4-Lite.
 * Assumes all source inputs arrive asynchronously and are synchronised
 * here; the system clock keeps running in sleep.
 */
// Chosen here: the register offsets and the AXI4-Lite slave port.
module signal_modulator (
   // clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // axi4-lite write address and data
   input wire logic [3:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   // axi4-lite write response
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   // axi4-lite read
   input wire logic [3:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   // modulator sources
   input wire logic modulation_input_pin,
   input wire logic pwm_output,
   input wire logic comparator_one,
   input wire logic serial_data_output,
   input wire logic uart_transmit,
   // carrier sources
   input wire logic first_carrier_input_pin,
   input wire logic second_carrier_input_pin,
   input wire logic reference_clock_output,
   // output pin
   output logic modulated_output,
   output logic slew_limit_enable,
   // peripheral pin release
   output logic modulation_source_pin_release,
   output logic high_carrier_pin_release,
   output logic low_carrier_pin_release
);
   import signal_modulator_pkg::*;

   logic [7:0] modulation_control;
   logic [7:0] modulation_source_select_register;
   logic [7:0] high_carrier_control;
   logic [7:0] low_carrier_control;
   logic [7:0] src_meta;
   logic [7:0] src_sync;
   logic [3:0] waddr;
   logic [31:0] wdata;
   logic [3:0] wstrb;
   logic have_addr;
   logic have_data;
   logic module_enable;
   logic mod_level;
   logic high_car;
   logic low_car;
   logic use_high;
   logic next_use_high;
   logic mixed;
   logic status_meta;
   logic status_sync;

   // every source input is asynchronous: two flops before any logic
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         src_meta <= 8'h00;
         src_sync <= 8'h00;
      end else begin
         src_meta <= {reference_clock_output, second_carrier_input_pin,
                      first_carrier_input_pin, uart_transmit,
                      serial_data_output, comparator_one, pwm_output,
                      modulation_input_pin};
         src_sync <= src_meta;
      end
   end

   assign module_enable = modulation_control[BIT_ENABLE];

   // modulator mux; disabled module falls back to the software bit
   always_comb begin
      mod_level = 1'b0;
      if (!module_enable) begin
         mod_level = modulation_control[BIT_SW_MOD];
      end else begin
         unique case (modulation_source_select_register[3:0])
            MOD_SW_BIT: mod_level = modulation_control[BIT_SW_MOD];
            MOD_PIN: mod_level = src_sync[0];
            MOD_PWM: mod_level = src_sync[1];
            MOD_COMPARATOR: mod_level = src_sync[2];
            MOD_SERIAL_DATA: mod_level = src_sync[3];
            MOD_UART_TX: mod_level = src_sync[4];
            default: mod_level = 1'b0;
         endcase
      end
   end

   // carrier muxes; only the high carrier may use the second pin
   function automatic logic pick_carrier(input logic [3:0] sel,
                                         input logic allow_pin_two,
                                         input logic [7:0] src);
      logic val;
      val = 1'b0;
      unique case (sel)
         CAR_GROUND: val = 1'b0;
         CAR_PIN_ONE: val = src[5];
         CAR_PIN_TWO: val = allow_pin_two & src[6];
         CAR_REF_CLOCK: val = src[7];
         CAR_PWM: val = src[1];
         default: val = 1'b0;
      endcase
      return val;
   endfunction : pick_carrier

   // carriers with polarity; grounded (no inversion) while disabled
   always_comb begin
      high_car = 1'b0;
      low_car = 1'b0;
      if (module_enable) begin
         high_car = pick_carrier(high_carrier_control[3:0], 1'b1, src_sync)
            ^ high_carrier_control[BIT_CAR_INV];
         low_car = pick_carrier(low_carrier_control[3:0], 1'b0, src_sync)
            ^ low_carrier_control[BIT_CAR_INV];
      end
   end

   // carrier choice: a synced carrier is held until its pulse falls low
   always_comb begin
      next_use_high = mod_level;
      if (use_high && !mod_level && high_carrier_control[BIT_CAR_SYNC]
          && high_car) begin
         next_use_high = 1'b1;
      end else if (!use_high && mod_level
                   && low_carrier_control[BIT_CAR_SYNC] && low_car) begin
         next_use_high = 1'b0;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         use_high <= 1'b0;
      end else begin
         use_high <= next_use_high;
      end
   end

   // mixing keeps running whatever the pin enable or sleep state
   assign mixed = module_enable &
                  (next_use_high ? high_car : low_car);

   // pin driver is a flop; low when the pin output is disconnected
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         modulated_output <= 1'b0;
      end else if (!modulation_control[BIT_PIN_OE]) begin
         modulated_output <= 1'b0;
      end else begin
         modulated_output <= mixed ^ modulation_control[BIT_OUT_INV];
      end
   end

   // pad controls come straight from flops
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         slew_limit_enable <= 1'b1;
         modulation_source_pin_release <= 1'b0;
         high_carrier_pin_release <= 1'b0;
         low_carrier_pin_release <= 1'b0;
      end else begin
         slew_limit_enable <= modulation_control[BIT_SLEW];
         modulation_source_pin_release <=
            modulation_source_select_register[BIT_RELEASE];
         high_carrier_pin_release <= high_carrier_control[BIT_RELEASE];
         low_carrier_pin_release <= low_carrier_control[BIT_RELEASE];
      end
   end

   // status crossing; mixed may toggle faster than software can sample
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         status_meta <= 1'b0;
         status_sync <= 1'b0;
      end else begin
         status_meta <= mixed ^ modulation_control[BIT_OUT_INV];
         status_sync <= status_meta;
      end
   end

   // write address and data captured in either order
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         have_addr <= 1'b0;
         have_data <= 1'b0;
         waddr <= 4'h0;
         wdata <= 32'h0000_0000;
         wstrb <= 4'h0;
      end else if (have_addr && have_data) begin
         have_addr <= 1'b0;
         have_data <= 1'b0;
      end else begin
         if (s_axi_awvalid && s_axi_awready) begin
            have_addr <= 1'b1;
            waddr <= s_axi_awaddr;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            have_data <= 1'b1;
            wdata <= s_axi_wdata;
            wstrb <= s_axi_wstrb;
         end
      end
   end

   // ready only while the matching slot is free and no response pending
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_awready <= 1'b0;
         s_axi_wready <= 1'b0;
      end else begin
         s_axi_awready <= !have_addr && !s_axi_bvalid && !s_axi_awready
                          && !(have_data && have_addr);
         s_axi_wready <= !have_data && !s_axi_bvalid && !s_axi_wready
                         && !(have_data && have_addr);
      end
   end

   // register writes; only byte lane 0 carries data
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         modulation_control <= CONTROL_RESET;
         modulation_source_select_register <= SOURCE_RESET;
         high_carrier_control <= CARRIER_RESET;
         low_carrier_control <= CARRIER_RESET;
      end else if (have_addr && have_data && wstrb[0]) begin
         unique case (waddr[3:2])
            OFS_CONTROL[3:2]:
               modulation_control <= wdata[7:0] & CONTROL_WMASK;
            OFS_SOURCE[3:2]:
               modulation_source_select_register <=
                  wdata[7:0] & SOURCE_WMASK;
            OFS_HIGH_CARRIER[3:2]:
               high_carrier_control <= wdata[7:0] & CARRIER_WMASK;
            OFS_LOW_CARRIER[3:2]:
               low_carrier_control <= wdata[7:0] & CARRIER_WMASK;
         endcase
      end
   end

   // write response one cycle after both halves are held
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= RESP_OKAY;
      end else if (have_addr && have_data) begin
         s_axi_bvalid <= 1'b1;
         s_axi_bresp <= RESP_OKAY;
      end else if (s_axi_bvalid && s_axi_bready) begin
         s_axi_bvalid <= 1'b0;
      end
   end

   // read channel: one outstanding read, status bit comes from the sync
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h0000_0000;
         s_axi_rresp <= RESP_OKAY;
      end else if (s_axi_arvalid && s_axi_arready) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid <= 1'b1;
         s_axi_rresp <= RESP_OKAY;
         unique case (s_axi_araddr[3:2])
            OFS_CONTROL[3:2]:
               s_axi_rdata <= {24'h000000, modulation_control[7:4],
                               status_sync, 2'b00,
                               modulation_control[0]};
            OFS_SOURCE[3:2]:
               s_axi_rdata <= {24'h000000,
                               modulation_source_select_register};
            OFS_HIGH_CARRIER[3:2]:
               s_axi_rdata <= {24'h000000, high_carrier_control};
            OFS_LOW_CARRIER[3:2]:
               s_axi_rdata <= {24'h000000, low_carrier_control};
         endcase
      end else if (s_axi_rvalid) begin
         if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
         end
      end else begin
         s_axi_arready <= !s_axi_arready;
      end
   end
endmodule : signal_modulator

// File: sim/signal_modulator_props.sv
/* port checker for signal_modulator: bus timing, reset state, outputs.
   assumes one clock aclk and synchronous active-low aresetn */
module signal_modulator_props (
   // clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // bus handshakes
   input wire logic s_axi_awvalid,
   input wire logic s_axi_awready,
   input wire logic s_axi_wvalid,
   input wire logic s_axi_wready,
   input wire logic s_axi_bvalid,
   input wire logic [1:0] s_axi_bresp,
   input wire logic [3:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   input wire logic s_axi_arready,
   input wire logic s_axi_rvalid,
   input wire logic [31:0] s_axi_rdata,
   // pin side
   input wire logic modulated_output,
   input wire logic slew_limit_enable,
   input wire logic modulation_source_pin_release,
   input wire logic high_carrier_pin_release,
   input wire logic low_carrier_pin_release
);
   logic [1:0] rd_idx;

   // register index of the read in flight; unused bits differ per register
   always_ff @(posedge aclk) begin
      if (s_axi_arvalid && s_axi_arready) begin
         rd_idx <= s_axi_araddr[3:2];
      end
   end

   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);
   // reset must win even while held, so no disable here
   reset_state_a: assert property (disable iff (1'b0)
      !aresetn |=> !modulated_output && slew_limit_enable)
      else $error("outputs not at reset state");
   wr_resp_time_a: assert property (s_axi_awvalid && s_axi_awready &&
      s_axi_wvalid && s_axi_wready |-> ##2 s_axi_bvalid)
      else $error("write response late");
   rd_resp_time_a: assert property (s_axi_arvalid && s_axi_arready
      |=> s_axi_rvalid) else $error("read data late");
   read_zero_a: assert property (s_axi_rvalid |->
      s_axi_rdata[31:8] == 24'h0
      && (rd_idx != 2'h0 || s_axi_rdata[2:1] == 2'h0)
      && (rd_idx != 2'h1 || s_axi_rdata[6:4] == 3'h0)
      && (rd_idx < 2'h2 || !s_axi_rdata[4]))
      else $error("unused bits not zero");
   write_busy_a: assert property (s_axi_bvalid |->
      !s_axi_awready && !s_axi_wready) else $error("ready while busy");
   bresp_okay_a: assert property (s_axi_bvalid |-> s_axi_bresp == 2'h0)
      else $error("write response not okay");
   // slew and releases only move around a register write
   slew_follow_a: assert property ($changed(slew_limit_enable) |->
      s_axi_bvalid || $past(s_axi_bvalid) || !$past(aresetn))
      else $error("slew moved without write");
   release_follow_a: assert property ($changed({
      modulation_source_pin_release, high_carrier_pin_release,
      low_carrier_pin_release}) |-> s_axi_bvalid || $past(s_axi_bvalid)
      || !$past(aresetn)) else $error("release moved without write");
   cover property (s_axi_rvalid && s_axi_rdata[3]);
   cover property ($fell(modulated_output));
   cover property ($rose(high_carrier_pin_release));
endmodule : signal_modulator_props

bind signal_modulator signal_modulator_props u_props (.aclk, .aresetn,
   .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready,
   .s_axi_bvalid, .s_axi_bresp, .s_axi_araddr, .s_axi_arvalid,
   .s_axi_arready,
   .s_axi_rvalid, .s_axi_rdata, .modulated_output, .slew_limit_enable,
   .modulation_source_pin_release, .high_carrier_pin_release,
   .low_carrier_pin_release);

// File: sim/source_model.sv
/* far-side sources: peripherals and pins feeding the modulator.
   assumes the bench sets the wanted levels, taken at a clock edge */
module source_model (
   // clock and wanted levels
   input wire logic aclk,
   input wire logic [7:0] levels,
   // source outputs
   output logic [7:0] src_lines
);
   timeunit 1ns;
   timeprecision 1ps;
   // levels move just after an edge, like a clocked peripheral would
   always_ff @(posedge aclk) begin
      src_lines <= levels;
   end
endmodule : source_model

// File: sim/tb.sv
/* self-checking bench for signal_modulator over axi4-lite.
   assumes source_model supplies all source pins */
module tb;
   timeunit 1ns;
   timeprecision 1ps;
   import signal_modulator_pkg::*;
   logic aclk = 1'b0;
   logic aresetn = 1'b0;
   logic [3:0] s_axi_awaddr = 4'h0;
   logic [3:0] s_axi_araddr = 4'h0;
   logic [31:0] s_axi_wdata = 32'h0;
   logic [3:0] s_axi_wstrb = 4'hF;
   logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
   logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
   logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
   logic s_axi_rvalid;
   logic [1:0] s_axi_bresp, s_axi_rresp;
   logic [31:0] s_axi_rdata;
   logic [7:0] sl;
   logic modulated_output, slew_limit_enable, modulation_source_pin_release;
   logic high_carrier_pin_release, low_carrier_pin_release;
   logic [7:0] levels = 8'h00;
   logic [7:0] ctl, src, hc, lc, r;
   logic [7:0] exp_q[$];
   int n_mismatch = 0;
   int num_checks = 0;

   always #20 aclk = ~aclk;

   source_model partner (.aclk(aclk), .levels(levels), .src_lines(sl));
   signal_modulator dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid,
      .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
      .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
      .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
      .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
      .modulation_input_pin(sl[0]), .pwm_output(sl[1]),
      .comparator_one(sl[2]), .serial_data_output(sl[3]),
      .uart_transmit(sl[4]), .first_carrier_input_pin(sl[5]),
      .second_carrier_input_pin(sl[6]), .reference_clock_output(sl[7]),
      .modulated_output, .slew_limit_enable, .modulation_source_pin_release,
      .high_carrier_pin_release, .low_carrier_pin_release);

   task automatic give_verdict();
      $display("checks %0d mismatches %0d", num_checks, n_mismatch);
      if (n_mismatch == 0 && num_checks > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask : give_verdict

   task automatic fail(input string msg);
      n_mismatch++;
      $display("mismatch at %0t: %s", $time, msg);
   endtask : fail

   task automatic chk(input logic got, input logic exp, input string what);
      num_checks++;
      if (got !== exp) fail(what);
   endtask : chk

   // one edge of a bounded wait; a hang ends the run
   task automatic tick(inout int n);
      @(posedge aclk);
      n++;
      if (n > 100) begin
         fail("bus timeout");
         give_verdict();
      end
   endtask : tick

   task automatic wr(input logic [3:0] a, input logic [7:0] d);
      int n;
      logic aw_left, w_left;
      n = 0;
      aw_left = 1'b1;
      w_left = 1'b1;
      @(posedge aclk);
      s_axi_awaddr <= a;
      s_axi_wdata <= {24'h0, d};
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      do begin
         tick(n);
         if (aw_left && s_axi_awready) begin
            aw_left = 1'b0;
            s_axi_awvalid <= 1'b0;
         end
         if (w_left && s_axi_wready) begin
            w_left = 1'b0;
            s_axi_wvalid <= 1'b0;
         end
      end while (aw_left || w_left);
      do tick(n); while (s_axi_bvalid !== 1'b1);
      s_axi_bready <= 1'b0;
   endtask : wr

   // read noting the expected byte for the watcher
   task automatic rd(input logic [3:0] a, input logic [7:0] e);
      int n;
      n = 0;
      @(posedge aclk);
      exp_q.push_back(e);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      do tick(n); while (s_axi_arready !== 1'b1);
      s_axi_arvalid <= 1'b0;
      do tick(n); while (s_axi_rvalid !== 1'b1);
      s_axi_rready <= 1'b0;
   endtask : rd

   // pairs each returned word with the oldest expectation
   always @(posedge aclk) begin
      if (s_axi_rvalid === 1'b1 && s_axi_rready === 1'b1) begin
         num_checks++;
         if (exp_q.size() == 0) fail("unexpected read");
         else if (s_axi_rdata !== {24'h0, exp_q.pop_front()}) fail("rdata");
         num_checks++;
         if (s_axi_rresp !== RESP_OKAY) fail("rresp");
      end
   end

   function automatic logic carsel(input logic [7:0] c, input logic hi);
      logic v;
      case (c[3:0])
         CAR_PIN_ONE: v = levels[5];
         CAR_PIN_TWO: v = hi & levels[6];
         CAR_REF_CLOCK: v = levels[7];
         CAR_PWM: v = levels[1];
         default: v = 1'b0;
      endcase
      return v ^ c[BIT_CAR_INV];
   endfunction : carsel

   // expected level before pin gating
   function automatic logic mixed();
      logic m;
      if (!ctl[BIT_ENABLE]) return ctl[BIT_OUT_INV];
      case (src[3:0])
         MOD_SW_BIT: m = ctl[BIT_SW_MOD];
         MOD_PIN: m = levels[0];
         MOD_PWM: m = levels[1];
         MOD_COMPARATOR: m = levels[2];
         MOD_SERIAL_DATA: m = levels[3];
         MOD_UART_TX: m = levels[4];
         default: m = 1'b0;
      endcase
      return (m ? carsel(hc, 1'b1) : carsel(lc, 1'b0)) ^ ctl[BIT_OUT_INV];
   endfunction : mixed

   // six edges cover partner, two sync flops, mix and status flops
   task automatic check_state();
      logic v;
      repeat (6) @(posedge aclk);
      v = mixed();
      chk(modulated_output, ctl[BIT_PIN_OE] & v, "pin");
      chk(slew_limit_enable, ctl[BIT_SLEW], "slew");
      chk(modulation_source_pin_release, src[7], "mod release");
      chk(high_carrier_pin_release, hc[7], "high release");
      chk(low_carrier_pin_release, lc[7], "low release");
      rd(OFS_CONTROL, (ctl & CONTROL_WMASK) | {4'h0, v, 3'h0});
   endtask : check_state

   task automatic setup(input logic [7:0] c, s, h, l);
      ctl = c;
      src = s;
      hc = h;
      lc = l;
      wr(OFS_SOURCE, s);
      wr(OFS_HIGH_CARRIER, h);
      wr(OFS_LOW_CARRIER, l);
      wr(OFS_CONTROL, c);
   endtask : setup

   initial begin
      void'($urandom(3));
      repeat (8) @(posedge aclk);
      aresetn <= 1'b1;
      {ctl, src, hc, lc} = {CONTROL_RESET, 24'h0};
      rd(OFS_SOURCE, SOURCE_RESET);
      rd(OFS_HIGH_CARRIER, CARRIER_RESET);
      rd(OFS_LOW_CARRIER, CARRIER_RESET);
      check_state();
      // every code of each field, enable forced on half the passes
      for (int i = 0; i < 64; i++) begin
         r = 8'($urandom);
         levels <= 8'($urandom);
         setup(r | {i[4], 7'h0}, {r[7:4], i[3:0]},
            {r[3:0] & 4'hD, i[3:0] ^ 4'h3},
            {r[5:2] & 4'hD, i[3:0] ^ 4'h5});
         check_state();
         rd(OFS_SOURCE, src & SOURCE_WMASK);
         rd(OFS_HIGH_CARRIER, hc & CARRIER_WMASK);
         rd(OFS_LOW_CARRIER, lc & CARRIER_WMASK);
      end
      // high carrier pulse in flight when the modulator drops
      for (int s = 0; s < 2; s++) begin
         levels <= 8'h20;
         setup(8'hC1, 8'h00, {2'b00, s[0], 5'h01}, 8'h00);
         check_state();
         ctl = 8'hC0;
         wr(OFS_CONTROL, ctl);
         repeat (6) @(posedge aclk);
         chk(modulated_output, s[0], "held pulse");
         levels <= 8'h00;
         repeat (6) @(posedge aclk);
         chk(modulated_output, 1'b0, "pulse end");
         levels <= 8'h20;
         repeat (6) @(posedge aclk);
         chk(modulated_output, 1'b0, "low carrier");
      end
      give_verdict();
   end
endmodule : tb
